/* hw/cmbu_bus_unit.sv */
// multiplexed bus unit: address formation and T1..T4 bus cycle sequencer
//
`timescale 1ns/1ps
module cmbu_bus_unit (
	input  wire logic                 ref_clk,
	input  wire logic                 sys_rst,
	input  wire logic                 config_strap,
	input  wire logic                 ready_pin,
	input  wire logic [7:0]           low_addr_data_in,
	input  wire logic [15:0]          code_segment_base,
	input  wire logic [15:0]          stack_segment_base,
	input  wire logic [15:0]          data_segment_base,
	input  wire logic [15:0]          extra_segment_base,
	input  wire logic                 int_enable_flag,
	input  wire logic                 req_valid,
	input  wire cmbu_pkg::cmbu_req_t  req,
	input  wire cmbu_pkg::cmbu_queue_t queue_op,
	input  wire logic                 lock_req,
	output logic                      req_ready,
	output logic                      rsp_valid,
	output logic [15:0]               rsp_data,
	output logic [19:0]               fetch_addr,
	output cmbu_pkg::cmbu_pins_t      pins,
	output logic                      lock_n,
	output logic                      queue_track_high,
	output logic                      queue_track_low,
	output logic                      int_enable_echo,
	output logic                      fixed_zero_status
);
	// ------------------------------------------------------------------------
	// state machine
	// ------------------------------------------------------------------------
	typedef enum logic [2:0] {
		CMBU_TI = 3'b000,
		CMBU_T1 = 3'b001,
		CMBU_T2 = 3'b010,
		CMBU_T3 = 3'b011,
		CMBU_TW = 3'b100,
		CMBU_T4 = 3'b101
	} cmbu_state_t;

	cmbu_state_t          state_q;
	cmbu_state_t          state_d;
	cmbu_pkg::cmbu_req_t  cur_q;
	logic [19:0]          addr_q;
	logic                 second_q;
	logic [7:0]           low_byte_q;
	logic [19:0]          fetch_q;
	logic [1:0]           rdy_sync_q;
	logic                 strap_meta_q;
	logic                 strap_q;
	logic [1:0]           queue_q;
	logic                 lock_q;

	// ------------------------------------------------------------------------
	// address formation
	// ------------------------------------------------------------------------
	function automatic logic [19:0] cmbu_phys(input logic [15:0] base, input logic [15:0] off);
		cmbu_phys = {base, 4'h0} + {4'h0, off};
	endfunction : cmbu_phys

	wire cmbu_pkg::cmbu_seg_t seg_auto =
		(req.ref_kind == cmbu_pkg::CMBU_REF_FETCH) ? cmbu_pkg::CMBU_SEG_CODE  :
		(req.ref_kind == cmbu_pkg::CMBU_REF_STACK) ? cmbu_pkg::CMBU_SEG_STACK :
		(req.ref_kind == cmbu_pkg::CMBU_REF_STRD)  ? cmbu_pkg::CMBU_SEG_EXTRA :
		                                             cmbu_pkg::CMBU_SEG_DATA;
	wire override_ok = req.seg_ovr && req.ref_kind == cmbu_pkg::CMBU_REF_DATA;
	wire cmbu_pkg::cmbu_seg_t seg_sel = override_ok ? req.ovr_seg : seg_auto;
	wire [15:0] base_sel =
		(seg_sel == cmbu_pkg::CMBU_SEG_CODE)  ? code_segment_base  :
		(seg_sel == cmbu_pkg::CMBU_SEG_STACK) ? stack_segment_base :
		(seg_sel == cmbu_pkg::CMBU_SEG_EXTRA) ? extra_segment_base : data_segment_base;
	wire is_io = req.kind == cmbu_pkg::CMBU_CY_IORD || req.kind == cmbu_pkg::CMBU_CY_IOWR;
	wire [15:0] port_addr = req.port_direct ? {8'h00, req.offset[7:0]} : req.offset;
	wire [19:0] first_addr = is_io ? {4'h0, port_addr} : cmbu_phys(base_sel, req.offset);
	wire cur_io = cur_q.kind == cmbu_pkg::CMBU_CY_IORD || cur_q.kind == cmbu_pkg::CMBU_CY_IOWR;
	// high byte lives at the next address, wrapping inside the segment or port space
	wire [15:0] off_next = cur_q.offset + 16'h0001;
	wire [19:0] seg_base_cur = addr_q - {4'h0, cur_q.offset};
	wire [19:0] next_addr = cur_io ? {4'h0, off_next} : seg_base_cur + {4'h0, off_next};
	wire is_read = cur_q.kind == cmbu_pkg::CMBU_CY_IORD || cur_q.kind == cmbu_pkg::CMBU_CY_MEMRD ||
		cur_q.kind == cmbu_pkg::CMBU_CY_FETCH || cur_q.kind == cmbu_pkg::CMBU_CY_INTA;
	wire cur_seg_code = cur_q.kind == cmbu_pkg::CMBU_CY_FETCH || cur_io;

	// ------------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------------
	wire ready_s = rdy_sync_q[1];
	wire more    = cur_q.word && !second_q;
	assign req_ready = state_q == CMBU_TI ? 1'b1 : 1'b0;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			CMBU_TI: if (req_valid) state_d = CMBU_T1;
			CMBU_T1: state_d = CMBU_T2;
			CMBU_T2: state_d = CMBU_T3;
			CMBU_T3: state_d = ready_s ? CMBU_T4 : CMBU_TW;
			CMBU_TW: state_d = ready_s ? CMBU_T4 : CMBU_TW;
			CMBU_T4: state_d = more ? CMBU_T1 : CMBU_TI;
			default: state_d = CMBU_TI;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_q    <= CMBU_TI;
			cur_q      <= '0;
			addr_q     <= 20'h00000;
			second_q   <= 1'b0;
			low_byte_q <= 8'h00;
			rsp_valid  <= 1'b0;
			rsp_data   <= 16'h0000;
			rdy_sync_q <= 2'b00;
			strap_meta_q <= 1'b1;
			strap_q    <= 1'b1;
			queue_q    <= 2'b00;
			lock_q     <= 1'b0;
			fetch_q    <= cmbu_pkg::RESET_FETCH;
		end else begin
			state_q    <= state_d;
			rdy_sync_q <= {rdy_sync_q[0], ready_pin};
			// strap is a pin: two flops before any logic reads it
			strap_meta_q <= config_strap;
			strap_q    <= strap_meta_q;
			queue_q    <= queue_op;
			lock_q     <= lock_req;
			rsp_valid  <= 1'b0;
			if (state_q == CMBU_TI && req_valid) begin
				cur_q    <= req;
				addr_q   <= first_addr;
				second_q <= 1'b0;
			end
			if (state_d == CMBU_T4 && is_read && !second_q)
				low_byte_q <= low_addr_data_in;
			if (state_q == CMBU_T4) begin
				if (more) begin
					second_q <= 1'b1;
					addr_q   <= next_addr;
				end else begin
					rsp_valid <= 1'b1;
					rsp_data  <= cur_q.word ? {low_addr_data_in, low_byte_q} : {8'h00, low_addr_data_in};
					if (cur_q.kind == cmbu_pkg::CMBU_CY_FETCH)
						fetch_q <= addr_q + 20'h00001;
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// pin drive
	// ------------------------------------------------------------------------
	wire in_cycle = state_q != CMBU_TI;
	wire [7:0] wr_byte = second_q ? cur_q.wdata[15:8] : cur_q.wdata[7:0];
	wire cmbu_pkg::cmbu_seg_t seg_now = cur_seg_code ? cmbu_pkg::CMBU_SEG_CODE :
		(cur_q.ref_kind == cmbu_pkg::CMBU_REF_STACK) ? cmbu_pkg::CMBU_SEG_STACK :
		(cur_q.ref_kind == cmbu_pkg::CMBU_REF_STRD)  ? cmbu_pkg::CMBU_SEG_EXTRA :
		(cur_q.seg_ovr ? cur_q.ovr_seg : cmbu_pkg::CMBU_SEG_DATA);
	wire [3:0] status4 = {1'b0, int_enable_flag, seg_now[1], seg_now[0]};

	always_comb begin
		pins.mid_address_lines      = addr_q[15:8];
		pins.high_addr_status_lines = (state_q == CMBU_T1) ? addr_q[19:16] :
			(in_cycle ? status4 : 4'h0);
		pins.low_addr_data_lines    = (state_q == CMBU_T1) ? addr_q[7:0] : wr_byte;
		pins.low_oe                 = state_q == CMBU_T1 || (in_cycle && !is_read);
		pins.ale                    = strap_q && state_q == CMBU_T1;
		pins.transfer_direction     = !is_read;
		pins.data_enable_strobe_n   = !(strap_q && in_cycle && state_q != CMBU_T1 &&
			(is_read ? state_q != CMBU_T2 : 1'b1));
		pins.cycle_type_n           = (!strap_q && (state_q == CMBU_T1 || state_q == CMBU_T2))
			? cur_q.kind : cmbu_pkg::CMBU_CY_PASS;
	end

	assign lock_n            = !(lock_q && !strap_q);
	assign queue_track_high  = strap_q ? 1'b0 : queue_q[1];
	assign queue_track_low   = strap_q ? 1'b0 : queue_q[0];
	assign int_enable_echo   = int_enable_flag;
	assign fixed_zero_status = 1'b0;
	assign fetch_addr        = fetch_q;

	// ------------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------------
	AST_T1_FOLLOWS: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state_q == CMBU_T1 |=> state_q == CMBU_T2 ##1 state_q == CMBU_T3)
		else $error("bus cycle did not run T1 T2 T3");
	AST_WAIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == CMBU_T3 && !ready_s) |=> state_q == CMBU_TW)
		else $error("missing wait state");
	AST_ALE_T1: assert property (@(posedge ref_clk) disable iff (sys_rst)
		pins.ale |-> state_q == CMBU_T1)
		else $error("address latch strobe outside T1");
	AST_IDLE_PASS: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state_q == CMBU_TI |-> pins.cycle_type_n == cmbu_pkg::CMBU_CY_PASS && !pins.ale)
		else $error("idle not passive");
	AST_IO_HIGH: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == CMBU_T1 && cur_io) |-> pins.high_addr_status_lines == 4'h0)
		else $error("I/O upper address not zero");
	AST_WORD_TWO: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == CMBU_T4 && more) |=> state_q == CMBU_T1 && second_q)
		else $error("word did not take second cycle");
	AST_S6_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(in_cycle && state_q != CMBU_T1) |-> !pins.high_addr_status_lines[3])
		else $error("status bit 6 not zero");
	AST_MID_STEADY: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == CMBU_T2) |=> $stable(pins.mid_address_lines))
		else $error("middle address moved within cycle");
	AST_RESET_FETCH: assert property (@(posedge ref_clk)
		$past(sys_rst) |-> fetch_addr == cmbu_pkg::RESET_FETCH)
		else $error("fetch address not at reset vector");

	// ------------------------------------------------------------------------
	// sequencing and pin timing
	// ------------------------------------------------------------------------
	AST_T3_READY: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == CMBU_T3 && ready_s) |=> state_q == CMBU_T4)
		else $error("ready T3 did not go to T4");
	AST_TW_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == CMBU_TW && !ready_s) |=> state_q == CMBU_TW)
		else $error("wait state left while not ready");
	AST_TW_END: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == CMBU_TW && ready_s) |=> state_q == CMBU_T4)
		else $error("wait state did not end in T4");
	AST_T4_IDLE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == CMBU_T4 && !more) |=> state_q == CMBU_TI)
		else $error("last cycle not followed by idle");
	AST_ADDR_T1: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state_q == CMBU_T1 |-> {pins.high_addr_status_lines, pins.mid_address_lines,
			pins.low_addr_data_lines} == addr_q)
		else $error("address not on bus in T1");
	AST_LOW_T1: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state_q == CMBU_T1 |-> pins.low_oe)
		else $error("low lines not driven in T1");
	AST_READ_FREE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(in_cycle && state_q != CMBU_T1 && is_read) |-> !pins.low_oe)
		else $error("low lines driven during read data phase");
	AST_T2_NO_DEN: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == CMBU_T2 && is_read) |-> pins.data_enable_strobe_n)
		else $error("data enable active in read T2");
	AST_DIR_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(strap_q && in_cycle && !is_read) |-> pins.transfer_direction)
		else $error("direction not transmit on write");
	AST_ALE_MIN: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == CMBU_T1 && strap_q) |-> pins.ale)
		else $error("no address latch strobe in T1");
	AST_MAX_QUIET: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!strap_q |-> pins.data_enable_strobe_n && !pins.ale)
		else $error("self strobes active in maximum mode");
	AST_MIN_PASS: assert property (@(posedge ref_clk) disable iff (sys_rst)
		strap_q |-> pins.cycle_type_n == cmbu_pkg::CMBU_CY_PASS)
		else $error("coded status active in minimum mode");
	AST_MAX_KIND: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(!strap_q && state_q == CMBU_T1) |-> pins.cycle_type_n == cur_q.kind)
		else $error("cycle type missing in T1");
	AST_IE_ECHO: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(in_cycle && state_q != CMBU_T1) |-> pins.high_addr_status_lines[2] == int_enable_flag)
		else $error("status bit 5 not interrupt enable");
	AST_IO_SEG: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(in_cycle && state_q != CMBU_T1 && cur_io) |-> pins.high_addr_status_lines[1:0] == 2'b10)
		else $error("I/O cycle segment status not none");
	AST_DIRECT_PORT: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == CMBU_TI && req_valid && is_io && req.port_direct) |=> addr_q[19:8] == 12'h000)
		else $error("direct port above first 256");
	AST_WORD_NEXT: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_q == CMBU_T4 && more) |=> addr_q == $past(next_addr))
		else $error("second byte not at next address");
	AST_QUEUE_MIN: assert property (@(posedge ref_clk) disable iff (sys_rst)
		strap_q |-> !queue_track_high && !queue_track_low)
		else $error("queue tracking active in minimum mode");
	AST_QUEUE_MAX: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(!strap_q && !$past(sys_rst)) |-> {queue_track_high, queue_track_low} == $past(queue_op))
		else $error("queue tracking not one clock after event");
	AST_LOCK_MAX: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!lock_n |-> !strap_q)
		else $error("lock active in minimum mode");
	AST_ZERO_PIN: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!fixed_zero_status && int_enable_echo == int_enable_flag)
		else $error("fixed status or echo wrong");
	AST_RSP_PULSE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rsp_valid |=> !rsp_valid)
		else $error("response longer than one clock");
	AST_NO_TAKE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		in_cycle |-> !req_ready)
		else $error("request accepted during a bus cycle");

	COV_READ: cover property (@(posedge ref_clk) state_q == CMBU_T4 && is_read);
	COV_WAIT: cover property (@(posedge ref_clk) state_q == CMBU_TW);
	COV_WORD: cover property (@(posedge ref_clk) state_q == CMBU_T1 && second_q);
	COV_MAX:  cover property (@(posedge ref_clk) !strap_q && state_q == CMBU_T1);
	// reads or writes inside the interrupt pointer area
	COV_VEC:  cover property (@(posedge ref_clk) state_q == CMBU_T1 && !cur_io && addr_q <= cmbu_pkg::VEC_TOP);
endmodule : cmbu_bus_unit

/* shared/cmbu_pkg.sv */
// package for the multiplexed bus unit: constants, codes and request carriers
// ----------------------------------------------------------------------------
// Contract
// - drive a 20-bit byte address covering 00000 to FFFFF.
// - segments span up to 64K bytes and start on 16-byte boundaries.
// - fetch uses code base, stack and frame use stack, strings extra, else data.
// - words may be odd aligned; low byte at lower address, high byte next.
// - every 16-bit operand runs as two consecutive byte bus cycles.
// - after reset, fetching starts at physical address FFFF0.
// - addresses 00000 to 003FF hold 256 four-byte interrupt pointers.
// - mode strap picks self-made strobes (high) or coded status (low).
// - minimum mode drives data enable, transfer direction and address latch strobe.
// - maximum mode drives cycle-type status, lock, queue tracking, request/grant (no request/grant pins here).
// - low lines share address/data, top four share address/status, middle steady.
// - each bus cycle is at least T1 to T4; address in T1, data T3/T4.
// - on reads, T2 turns the bus direction around.
// - not-ready inserts one-clock wait states between T3 and T4.
// - idle clocks may separate bus cycles.
// - an address latch pulse is issued in T1 of every bus cycle (here only in minimum mode, strap high).
// - cycle-type status encodes seven cycle kinds, 111 passive.
// - status bits 3 to 6 sit on upper lines from T2 to T4.
// - segment status: 00 extra, 01 stack, 10 code or none, 11 data.
// - status bit 5 echoes interrupt enable, status bit 6 is zero.
// - I/O uses 16-bit port address, upper four lines zero.
// - direct I/O reaches first 256 ports; pointer I/O uses full 16 bits.
// - queue tracking: 00 none, 01 first byte, 10 emptied, 11 subsequent.
// ----------------------------------------------------------------------------
package cmbu_pkg;
	localparam int           ADDR_W      = 20;
	localparam logic [19:0]  RESET_FETCH = 20'hFFFF0;
	localparam logic [19:0]  VEC_TOP     = 20'h003FF;
	localparam logic [3:0]   SEG_SHIFT   = 4'h4;

	typedef enum logic [2:0] {
		CMBU_CY_INTA  = 3'b000,
		CMBU_CY_IORD  = 3'b001,
		CMBU_CY_IOWR  = 3'b010,
		CMBU_CY_HALT  = 3'b011,
		CMBU_CY_FETCH = 3'b100,
		CMBU_CY_MEMRD = 3'b101,
		CMBU_CY_MEMWR = 3'b110,
		CMBU_CY_PASS  = 3'b111
	} cmbu_cycle_t;

	typedef enum logic [1:0] {
		CMBU_SEG_EXTRA = 2'b00,
		CMBU_SEG_STACK = 2'b01,
		CMBU_SEG_CODE  = 2'b10,
		CMBU_SEG_DATA  = 2'b11
	} cmbu_seg_t;

	typedef enum logic [1:0] {
		CMBU_REF_FETCH = 2'b00,
		CMBU_REF_STACK = 2'b01,
		CMBU_REF_STRD  = 2'b10,
		CMBU_REF_DATA  = 2'b11
	} cmbu_ref_t;

	typedef enum logic [1:0] {
		CMBU_Q_NONE  = 2'b00,
		CMBU_Q_FIRST = 2'b01,
		CMBU_Q_EMPTY = 2'b10,
		CMBU_Q_NEXT  = 2'b11
	} cmbu_queue_t;

	// one request from the execution side
	typedef struct packed {
		cmbu_cycle_t kind;
		cmbu_ref_t   ref_kind;
		logic        seg_ovr;
		cmbu_seg_t   ovr_seg;
		logic        word;
		logic        port_direct;
		logic [15:0] offset;
		logic [15:0] wdata;
	} cmbu_req_t;

	// pins seen by the outside world
	typedef struct packed {
		logic [7:0]  low_addr_data_lines;
		logic        low_oe;
		logic [7:0]  mid_address_lines;
		logic [3:0]  high_addr_status_lines;
		logic        ale;
		logic        data_enable_strobe_n;
		logic        transfer_direction;
		logic [2:0]  cycle_type_n;
	} cmbu_pins_t;
endpackage : cmbu_pkg

/* test/cmbu_far_model.sv */
// far side model: memory and port device with a programmable not-ready span
`timescale 1ns/1ps
module cmbu_far_model (
	input  wire logic                 ref_clk,
	input  wire cmbu_pkg::cmbu_pins_t pins,
	input  wire logic [3:0]           waits,
	output logic                      ready_pin,
	output logic [7:0]                low_addr_data_in
);
	logic [19:0] addr_q = 20'h00000;
	logic [3:0]  cnt_q = 4'h0;
	logic [7:0]  last_q = 8'h00;
	wire         rd_on = !pins.data_enable_strobe_n && !pins.transfer_direction;
	wire  [7:0]  mem_v = addr_q[7:0] ^ addr_q[15:8] ^ {2{addr_q[19:16]}};

	assign ready_pin = (cnt_q == 4'h0);
	// a released bus shows the inverse of the last byte, never a stale copy
	assign low_addr_data_in = rd_on ? mem_v : ~last_q;

	always @(negedge ref_clk) begin
		if (pins.ale) begin
			addr_q <= {pins.high_addr_status_lines, pins.mid_address_lines, pins.low_addr_data_lines};
			cnt_q <= waits;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end
		if (rd_on)
			last_q <= mem_v;
	end
endmodule : cmbu_far_model

/* test/cmbu_bus_unit_bench.sv */
// self-checking bench for the multiplexed bus unit
`timescale 1ns/1ps
module cmbu_bus_unit_bench;
	logic                  ref_clk = 1'b0;
	logic                  sys_rst = 1'b1;
	logic                  config_strap = 1'b1;
	logic                  ie = 1'b1;
	logic                  req_valid = 1'b0;
	logic                  lock_req = 1'b0;
	logic [15:0]           cs_b = 16'hFFFF;
	logic [15:0]           ss_b = 16'hFFFF;
	logic [15:0]           ds_b = 16'h1234;
	logic [15:0]           es_b = 16'h0100;
	logic [3:0]            waits = 4'h0;
	cmbu_pkg::cmbu_req_t   req = '0;
	cmbu_pkg::cmbu_queue_t queue_op = cmbu_pkg::CMBU_Q_NONE;
	cmbu_pkg::cmbu_pins_t  pins;
	logic                  ready_pin, req_ready, rsp_valid, lock_n, qt_h, qt_l, ie_echo, zero_st;
	logic [7:0]            low_in;
	logic [15:0]           rsp_data;
	logic [19:0]           fetch_addr;
	logic [19:0]           a_q[$];
	logic [3:0]            s_q[$];
	logic [2:0]            c_q[$];
	logic [7:0]            w_q[$];
	logic                  t2_q = 1'b0;
	logic                  w_p = 1'b0;
	logic [2:0]            ct_p = 3'h7;
	int                    err_count = 0;
	int                    n_tests = 0;
	int                    lat = 0;
	wire                   wr_on = !pins.data_enable_strobe_n && pins.transfer_direction;

	cmbu_bus_unit i_cmbu_bus_unit (.ref_clk(ref_clk), .sys_rst(sys_rst), .config_strap(config_strap),
		.ready_pin(ready_pin), .low_addr_data_in(low_in), .code_segment_base(cs_b),
		.stack_segment_base(ss_b), .data_segment_base(ds_b), .extra_segment_base(es_b),
		.int_enable_flag(ie), .req_valid(req_valid), .req(req), .queue_op(queue_op), .lock_req(lock_req),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .fetch_addr(fetch_addr),
		.pins(pins), .lock_n(lock_n), .queue_track_high(qt_h), .queue_track_low(qt_l),
		.int_enable_echo(ie_echo), .fixed_zero_status(zero_st));
	cmbu_far_model i_cmbu_far_model (.ref_clk(ref_clk), .pins(pins), .waits(waits),
		.ready_pin(ready_pin), .low_addr_data_in(low_in));

	initial forever #12.5 ref_clk = ~ref_clk;

	// ----------------------------------------------------------------
	// bus monitor
	// ----------------------------------------------------------------
	always @(negedge ref_clk) begin
		if (t2_q)
			s_q.push_back(pins.high_addr_status_lines);
		t2_q = pins.ale;
		if (pins.ale)
			a_q.push_back({pins.high_addr_status_lines, pins.mid_address_lines, pins.low_addr_data_lines});
		if (pins.cycle_type_n != 3'h7 && ct_p == 3'h7)
			c_q.push_back(pins.cycle_type_n);
		ct_p = pins.cycle_type_n;
		if (wr_on && !w_p)
			w_q.push_back(pins.low_addr_data_lines);
		w_p = wr_on;
	end

	function automatic logic [7:0] mv(input logic [19:0] a);
		return a[7:0] ^ a[15:8] ^ {2{a[19:16]}};
	endfunction : mv

	task automatic end_of_test();
		if (err_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [19:0] g, input logic [19:0] e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic op(input logic [2:0] k, input logic [1:0] r, input logic ov, w, pd, input logic [15:0] off, wd);
		int n;
		n = 0;
		a_q.delete();
		s_q.delete();
		c_q.delete();
		w_q.delete();
		@(negedge ref_clk);
		while (req_ready !== 1'b1 && n < 40) begin
			@(negedge ref_clk);
			n++;
		end
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req <= '{cmbu_pkg::cmbu_cycle_t'(k), cmbu_pkg::cmbu_ref_t'(r), ov, cmbu_pkg::CMBU_SEG_EXTRA, w, pd, off, wd};
		@(posedge ref_clk);
		req_valid <= 1'b0;
		lat = 0;
		do begin
			@(negedge ref_clk);
			lat++;
		end while (rsp_valid !== 1'b1 && lat < 40);
	endtask : op

	task automatic bus_chk(input logic [19:0] a0, a1, input logic [1:0] sg, input logic [3:0] nb, le);
		chk(a_q.size(), nb);
		chk(a_q[0], a0);
		if (nb == 4'h2)
			chk(a_q[1], a1);
		chk(s_q[0], {1'b0, ie, sg});
		if (le != 4'h0)
			chk(lat, le);
		chk(c_q.size(), 0);
	endtask : bus_chk

	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		end_of_test();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(negedge ref_clk);
		chk(fetch_addr, 20'hFFFF0);
		chk({pins.ale, pins.cycle_type_n}, 4'h7);
		op(cmbu_pkg::CMBU_CY_FETCH, cmbu_pkg::CMBU_REF_FETCH, 0, 0, 0, 16'h0000, 16'h0000);
		bus_chk(20'hFFFF0, 0, 2'h2, 1, 5);
		chk(fetch_addr, 20'hFFFF1);
		op(cmbu_pkg::CMBU_CY_MEMRD, cmbu_pkg::CMBU_REF_DATA, 0, 0, 0, 16'hFFFF, 16'h0000);
		bus_chk(20'h2233F, 0, 2'h3, 1, 5);
		chk(rsp_data[7:0], mv(20'h2233F));
		@(posedge ref_clk);
		ie <= 1'b0;
		op(cmbu_pkg::CMBU_CY_MEMRD, cmbu_pkg::CMBU_REF_STACK, 0, 1, 0, 16'h0020, 16'h0000);
		bus_chk(20'h00010, 20'h00011, 2'h1, 2, 9);
		chk(rsp_data, {mv(20'h00011), mv(20'h00010)});
		op(cmbu_pkg::CMBU_CY_MEMWR, cmbu_pkg::CMBU_REF_DATA, 1, 1, 0, 16'hFFFF, 16'hA55A);
		bus_chk(20'h10FFF, 20'h01000, 2'h0, 2, 9);
		chk({w_q[1], w_q[0]}, 16'hA55A);
		op(cmbu_pkg::CMBU_CY_MEMWR, cmbu_pkg::CMBU_REF_STRD, 0, 0, 0, 16'h0002, 16'h0077);
		bus_chk(20'h01002, 0, 2'h0, 1, 5);
		chk(w_q[0], 8'h77);
		op(cmbu_pkg::CMBU_CY_IORD, cmbu_pkg::CMBU_REF_DATA, 0, 0, 1, 16'h12AB, 16'h0000);
		bus_chk(20'h000AB, 0, 2'h2, 1, 5);
		op(cmbu_pkg::CMBU_CY_IOWR, cmbu_pkg::CMBU_REF_DATA, 0, 0, 0, 16'hBEEF, 16'h00C3);
		bus_chk(20'h0BEEF, 0, 2'h2, 1, 5);
		chk(w_q[0], 8'hC3);
		@(posedge ref_clk);
		waits <= 4'h3;
		op(cmbu_pkg::CMBU_CY_MEMRD, cmbu_pkg::CMBU_REF_DATA, 0, 0, 0, 16'h0005, 16'h0000);
		chk(lat > 5, 1);
		chk(rsp_data[7:0], mv(20'h12345));
		@(posedge ref_clk);
		waits <= 4'h0;
		config_strap <= 1'b0;
		lock_req <= 1'b1;
		for (int k = 0; k < 7; k++) begin
			op(k[2:0], cmbu_pkg::CMBU_REF_DATA, 0, 0, 0, 16'h0040, 16'h0000);
			chk(c_q[0], k[2:0]);
			chk(a_q.size(), 0);
		end
		for (int q = 0; q < 4; q++) begin
			@(posedge ref_clk);
			queue_op <= cmbu_pkg::cmbu_queue_t'(q);
			@(posedge ref_clk);
			queue_op <= cmbu_pkg::CMBU_Q_NONE;
			@(negedge ref_clk);
			chk({qt_h, qt_l}, q[1:0]);
		end
		chk(lock_n, 1'b0);
		chk({zero_st, ie_echo}, {1'b0, ie});
		chk({pins.ale, pins.cycle_type_n}, 4'h7);
		end_of_test();
	end
endmodule : cmbu_bus_unit_bench
